// ==== sim/capture_descriptor_queue_asserts.sv ====
`timescale 1ns/10ps
// Protocol checks on the ports of the capture channel.
module capture_descriptor_queue_asserts (
  input wire logic                 clk_in,
  input wire logic                 reset_n_in,
  input wire logic                 desc_valid_in,
  input wire logic                 desc_ready_out,
  input wire logic                 capturing_out,
  input wire logic                 frame_drop_out,
  input wire logic                 cur_valid_out,
  input wire logic                 shadow_valid_out,
  input wire logic                 track_valid_out,
  input wire capture_pkg::track_t  track_out,
  input wire logic                 wb_valid_out,
  input wire logic                 wb_ready_in,
  input wire capture_pkg::wb_rec_t wb_out,
  input wire logic                 wb_miss_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Two deliveries of one descriptor give exactly two adjacent reports.
  sequence pair_s;
    track_valid_out ##1 track_valid_out ##1 !track_valid_out;
  endsequence

  a_track_twice: assert property ($rose(track_valid_out) |-> pair_s)
    else $error("track pulses not paired");
  a_load_report: assert property (desc_valid_in && desc_ready_out
    |-> ##[3:9] track_valid_out)
    else $error("load not reported");
  // A completion in the delivery cycle frees a slot, so those cycles are left out.
  a_full_ignore: assert property (track_valid_out && !$fell(capturing_out)
    && $past(cur_valid_out && shadow_valid_out)
    |-> !track_out.accepted && cur_valid_out && shadow_valid_out)
    else $error("load into full channel taken");
  a_fill_order: assert property (track_valid_out && track_out.accepted
    && !$fell(capturing_out)
    |-> cur_valid_out && (shadow_valid_out || !$past(cur_valid_out)))
    else $error("accepted load not stored");
  a_drop_empty: assert property (frame_drop_out
    |-> !capturing_out && !$past(cur_valid_out))
    else $error("drop with descriptor held");
  a_capture_needs: assert property ($rose(capturing_out) |-> $past(cur_valid_out))
    else $error("capture without descriptor");
  // A load in the completion cycle may refill the shadow at once.
  a_shadow_promote: assert property ($fell(capturing_out) && $past(shadow_valid_out)
    |-> cur_valid_out && (!shadow_valid_out || track_valid_out))
    else $error("shadow not promoted");
  a_wb_hold: assert property (wb_valid_out && !wb_ready_in
    |=> wb_valid_out && $stable(wb_out))
    else $error("record not held");
  // A completion in the taking cycle posts the next record straight away.
  a_wb_taken: assert property (wb_valid_out && wb_ready_in
    |=> !wb_valid_out || $fell(capturing_out))
    else $error("record not released");
  a_miss_pulse: assert property (wb_miss_out |-> wb_valid_out ##1 !wb_miss_out)
    else $error("bad miss pulse");
endmodule

// ==== sim/capture_descriptor_queue_tb.sv ====
`timescale 1ns/10ps
// Self-checking bench for one capture channel.
module capture_descriptor_queue_tb;
  logic                  clk_in, reset_n_in, desc_valid_in, wb_ready_in, go, fid;
  logic                  desc_ready_out, capturing_out, frame_drop_out, cur_valid_out;
  logic                  shadow_valid_out, track_valid_out, wb_valid_out, wb_miss_out;
  logic                  src_start, src_end, src_field;
  capture_pkg::desc_t    desc_in;
  capture_pkg::track_t   track_out;
  capture_pkg::wb_rec_t  wb_out;
  int                    error_cnt, cmp_count, cyc;
  localparam capture_pkg::desc_t desc_a = {32'h10002000, 1'b1, 12'h2D0, 12'h1E0};
  localparam capture_pkg::desc_t desc_b = {32'h30004000, 1'b1, 12'h500, 12'h2D0};
  localparam capture_pkg::desc_t desc_c = {32'h50006000, 1'b0, 12'h140, 12'h0F0};

  capture_descriptor_queue uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .desc_valid_in(desc_valid_in), .desc_ready_out(desc_ready_out), .desc_in(desc_in),
    .frame_start_in(src_start), .frame_end_in(src_end), .field_id_in(src_field),
    .capturing_out(capturing_out), .frame_drop_out(frame_drop_out),
    .cur_valid_out(cur_valid_out), .shadow_valid_out(shadow_valid_out),
    .track_valid_out(track_valid_out), .track_out(track_out), .wb_valid_out(wb_valid_out),
    .wb_ready_in(wb_ready_in), .wb_out(wb_out), .wb_miss_out(wb_miss_out));
  video_source src (.clk_in(clk_in), .reset_n_in(reset_n_in), .go_in(go), .fid_in(fid),
    .start_out(src_start), .end_out(src_end), .field_out(src_field));

  // Clock and a cycle ceiling that cuts a hang short.
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      results();
    end
  end

  task tick;
    @(posedge clk_in);
    #1;
  endtask

  task check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task results;
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic capture_pkg::wb_rec_t wb_of(capture_pkg::desc_t d, logic f);
    return {d.wb_addr, f, d.width, d.height};
  endfunction

  // Consumer fills gaps.
  // A lost record is rebuilt from the last one: same size, field kept or flipped.
  function automatic capture_pkg::wb_rec_t infer(capture_pkg::wb_rec_t prev, logic interlaced);
    return {prev.addr, prev.field_id ^ interlaced, prev.width, prev.height};
  endfunction

  // One load; each of the two deliveries is reported with its own verdict.
  task load(input capture_pkg::desc_t d, input logic acc1, input logic acc2);
    repeat (20) if (desc_ready_out !== 1'b1) tick;
    check(desc_ready_out, 1'b1);
    desc_valid_in = 1'b1;
    desc_in = d;
    tick;
    desc_valid_in = 1'b0;
    repeat (12) if (track_valid_out !== 1'b1) tick;
    check(track_out, {d, acc1});
    tick;
    check(track_valid_out, 1'b1);
    check(track_out, {d, acc2});
    check({cur_valid_out, shadow_valid_out}, 2'h3);
    tick;
    check(track_valid_out, 1'b0);
  endtask

  // One frame from the source, watching capture, drop, records and lost records.
  task frame(input logic f, input logic cap, input logic miss, input logic rec);
    logic sc, sd, sm, sw;
    sc = 1'b0;
    sd = 1'b0;
    sm = 1'b0;
    sw = 1'b0;
    fid = f;
    go = 1'b1;
    tick;
    go = 1'b0;
    repeat (32)
    begin
      tick;
      sc = sc | (capturing_out === 1'b1);
      sd = sd | (frame_drop_out === 1'b1);
      sm = sm | (wb_miss_out === 1'b1);
      sw = sw | (wb_valid_out === 1'b1);
    end
    check(sc, cap);
    check(sd, !cap);
    check(sm, miss);
    check(sw, rec);
  endtask

  // Memory side takes the pending record.
  task drain;
    wb_ready_in = 1'b1;
    tick;
    wb_ready_in = 1'b0;
    tick;
    check(wb_valid_out, 1'b0);
  endtask

  // Fill both slots, then both deliveries of a second load must bounce off.
  task t_load;
    load(desc_a, 1'b1, 1'b1);
    load(desc_b, 1'b0, 1'b0);
  endtask

  // Frames with memory stalled, a lost record, then a frame with nothing queued.
  task t_frames;
    capture_pkg::wb_rec_t guess;
    frame(1'b0, 1'b1, 1'b0, 1'b1);
    check({cur_valid_out, shadow_valid_out}, 2'h2);
    check(wb_valid_out, 1'b1);
    check(wb_out, wb_of(desc_a, 1'b0));
    frame(1'b1, 1'b1, 1'b1, 1'b1);
    check({cur_valid_out, shadow_valid_out}, 2'h0);
    check(wb_out, wb_of(desc_a, 1'b0));
    guess = infer(wb_out, 1'b0);
    check(guess, wb_of(desc_a, 1'b0));
    guess = infer(wb_out, 1'b1);
    check(guess, wb_of(desc_a, 1'b1));
    check({guess.width, guess.height}, {desc_a.width, desc_a.height});
    check(guess.field_id, src_field);
    drain;
    frame(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  // Fresh descriptors bring capture back; a duplicate into a full channel bounces.
  task t_refill;
    load(desc_b, 1'b1, 1'b1);
    frame(1'b1, 1'b1, 1'b0, 1'b1);
    check(wb_out, wb_of(desc_b, 1'b1));
    load(desc_c, 1'b1, 1'b0);
    drain;
    frame(1'b0, 1'b1, 1'b0, 1'b1);
    check(wb_out, wb_of(desc_b, 1'b0));
    drain;
    frame(1'b1, 1'b1, 1'b0, 1'b0);
    check({cur_valid_out, shadow_valid_out}, 2'h0);
  endtask

  initial
  begin
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    desc_valid_in = 1'b0;
    desc_in = '0;
    wb_ready_in = 1'b0;
    go = 1'b0;
    fid = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (3) tick;
    reset_n_in = 1'b1;
    t_load;
    t_frames;
    t_refill;
    results;
  end
endmodule

bind capture_descriptor_queue capture_descriptor_queue_asserts chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .desc_valid_in(desc_valid_in), .desc_ready_out(desc_ready_out),
  .capturing_out(capturing_out), .frame_drop_out(frame_drop_out),
  .cur_valid_out(cur_valid_out), .shadow_valid_out(shadow_valid_out),
  .track_valid_out(track_valid_out), .track_out(track_out), .wb_valid_out(wb_valid_out),
  .wb_ready_in(wb_ready_in), .wb_out(wb_out), .wb_miss_out(wb_miss_out));

// ==== sim/video_source.sv ====
`timescale 1ns/10ps
// Behavioural video source that sends one frame for each go pulse received while idle.
module video_source (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic go_in,
  input  wire logic fid_in,
  output logic      start_out,
  output logic      end_out,
  output logic      field_out
);
  logic [4:0] cnt_q;

  // Frame timer; a go pulse during a frame is ignored so markers never overlap.
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      cnt_q <= 5'h00;
    else if (go_in && cnt_q == 5'h00)
      cnt_q <= 5'h14;
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
  end

  // Markers stay high four cycles each, long enough for the two-flop synchroniser.
  assign start_out = (cnt_q > 5'h10);
  assign end_out   = (cnt_q > 5'h04) && (cnt_q < 5'h09);
  assign field_out = fid_in;
endmodule

// ==== src/_unused_note.sv ====
`timescale 1ns/10ps

// ==== src/capture_descriptor_queue.sv ====
`timescale 1ns/10ps
// Descriptor handling of one capture channel of the video port DMA.
module capture_descriptor_queue (
  input  wire logic                    clk_in,
  input  wire logic                    reset_n_in,
  // Descriptor loads from the controlling party.
  input  wire logic                    desc_valid_in,
  output logic                         desc_ready_out,
  input  wire capture_pkg::desc_t      desc_in,
  // Frame markers from the external video source (asynchronous pins).
  input  wire logic                    frame_start_in,
  input  wire logic                    frame_end_in,
  input  wire logic                    field_id_in,
  // Channel status.
  output logic                         capturing_out,
  output logic                         frame_drop_out,
  output logic                         cur_valid_out,
  output logic                         shadow_valid_out,
  // Tracking unit report.
  output logic                         track_valid_out,
  output capture_pkg::track_t          track_out,
  // Write-back record toward memory.
  output logic                         wb_valid_out,
  input  wire logic                    wb_ready_in,
  output capture_pkg::wb_rec_t         wb_out,
  output logic                         wb_miss_out
);

  // Pin synchronisers; stage one is read only by stage two.
  logic [2:0] start_s1_q;
  logic [2:0] start_s2_q;
  logic [2:0] start_d_q;
  logic       sof;
  logic       eof;
  logic       field_sync;

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      start_s1_q <= '0;
      start_s2_q <= '0;
      start_d_q  <= '0;
    end
    else
    begin
      start_s1_q <= {field_id_in, frame_end_in, frame_start_in};
      start_s2_q <= start_s1_q;
      start_d_q  <= start_s2_q;
    end
  end

  // Rising edges of the synchronised start and end markers, one cycle each; field is taken as a level.
  assign sof        = start_s2_q[0] && !start_d_q[0];
  assign eof        = start_s2_q[1] && !start_d_q[1];
  assign field_sync = start_s2_q[2];

  // Buffer between the loader and the issuer; a busy issuer stalls the source only after the buffer fills, via desc_ready_out one cycle later.
  logic               buf_valid;
  logic               buf_ready;
  logic               desc_ready;
  capture_pkg::desc_t buf_desc;

  desc_buffer #(
    .WIDTH (capture_pkg::DESC_W),
    .DEPTH (capture_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (desc_valid_in),
    .in_ready_out  (desc_ready),
    .in_data_in    (desc_in),
    .out_valid_out (buf_valid),
    .out_ready_in  (buf_ready),
    .out_data_out  (buf_desc)
  );

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      desc_ready_out <= 1'b0;
    else
      desc_ready_out <= desc_ready;
  end

  // Issuer: holds one descriptor and hands it to the channel in two cycles.
  capture_pkg::issue_state_t issue_q;
  capture_pkg::desc_t        issue_desc_q;
  logic                      load;

  assign buf_ready = (issue_q == capture_pkg::ISSUE_IDLE);
  assign load      = (issue_q != capture_pkg::ISSUE_IDLE);

  // [RL6] Double delivery sequence.
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      issue_q      <= capture_pkg::ISSUE_IDLE;
      issue_desc_q <= capture_pkg::DESC_RESET;
    end
    else
    begin
      unique case (issue_q)
        capture_pkg::ISSUE_IDLE:
        begin
          if (buf_valid)
          begin
            issue_desc_q <= buf_desc;
            issue_q      <= capture_pkg::ISSUE_FIRST;
          end
        end
        capture_pkg::ISSUE_FIRST:
          issue_q <= capture_pkg::ISSUE_SECOND;
        capture_pkg::ISSUE_SECOND:
          issue_q <= capture_pkg::ISSUE_IDLE;
        default:
          issue_q <= capture_pkg::ISSUE_IDLE;
      endcase
    end
  end

  // Slot update: completion is applied first, then the load sees the freed slot.
  capture_pkg::desc_t cur_q;
  capture_pkg::desc_t cur_d;
  capture_pkg::desc_t shadow_q;
  capture_pkg::desc_t shadow_d;
  logic               cur_v_q;
  logic               cur_v_d;
  logic               sh_v_q;
  logic               sh_v_d;
  logic               complete;
  logic               accepted;

  assign complete = eof && capturing_out;

  always_comb
  begin
    cur_d    = cur_q;
    cur_v_d  = cur_v_q;
    shadow_d = shadow_q;
    sh_v_d   = sh_v_q;
    accepted = 1'b0;
    // [RL13] Promote the shadow.
    if (complete)
    begin
      cur_d   = shadow_q;
      cur_v_d = sh_v_q;
      sh_v_d  = 1'b0;
    end
    // [RL14] Store into a free slot.
    if (load && !cur_v_d)
    begin
      cur_d    = issue_desc_q;
      cur_v_d  = 1'b1;
      accepted = 1'b1;
    end
    else if (load && !sh_v_d)
    begin
      shadow_d = issue_desc_q;
      sh_v_d   = 1'b1;
      accepted = 1'b1;
    end
    // [RL3] Both slots full: the load falls through untouched.
  end

  // [RL1] Current and shadow slots.
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      cur_q    <= capture_pkg::DESC_RESET;
      shadow_q <= capture_pkg::DESC_RESET;
      cur_v_q  <= 1'b0;
      sh_v_q   <= 1'b0;
    end
    else
    begin
      cur_q    <= cur_d;
      shadow_q <= shadow_d;
      cur_v_q  <= cur_v_d;
      sh_v_q   <= sh_v_d;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      cur_valid_out    <= 1'b0;
      shadow_valid_out <= 1'b0;
    end
    else
    begin
      cur_valid_out    <= cur_v_d;
      shadow_valid_out <= sh_v_d;
    end
  end

  // [RL4] Report every delivery with its acceptance.
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      track_valid_out <= 1'b0;
      track_out       <= capture_pkg::TRACK_RESET;
    end
    else
    begin
      track_valid_out <= load;
      if (load)
        track_out <= '{desc: issue_desc_q, accepted: accepted};
    end
  end

  // [RL2] Frame start without a current descriptor is discarded.
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      capturing_out  <= 1'b0;
      frame_drop_out <= 1'b0;
    end
    else
    begin
      frame_drop_out <= sof && !capturing_out && !cur_v_q;
      if (complete)
        capturing_out <= 1'b0;
      else if (sof && cur_v_q)
        capturing_out <= 1'b1;
    end
  end

  // [RL12] Write-back record at completion when enabled.
  // [RL5] A busy memory side only loses the record; capture never waits.
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      wb_valid_out <= 1'b0;
      wb_out       <= capture_pkg::WB_RESET;
      wb_miss_out  <= 1'b0;
    end
    else
    begin
      wb_miss_out <= 1'b0;
      if (wb_valid_out && wb_ready_in)
        wb_valid_out <= 1'b0;
      if (complete && cur_q.wb_en)
      begin
        if (wb_valid_out && !wb_ready_in)
          wb_miss_out <= 1'b1;
        else
        begin
          wb_valid_out <= 1'b1;
          wb_out       <= '{addr: cur_q.wb_addr, field_id: field_sync,
                            width: cur_q.width, height: cur_q.height};
        end
      end
    end
  end

endmodule

// ==== src/capture_pkg.sv ====
// How it works
// [RL1] Each channel keeps a current and a shadow descriptor slot.
// [RL2] No shadow at completion leaves the next frame uncaptured and discarded.
// [RL3] A load while both slots are full is ignored, slots untouched.
// [RL4] Every issued descriptor is also reported to the tracking unit.
// [RL5] Write-back is informational and never affects frame capture.
// [RL6] The issuer delivers every descriptor to the channel twice.
// [RL7] Missing write-back: consumer reuses previous width and height.
// [RL8] Missing write-back, progressive: consumer reuses previous field identifier.
// [RL9] Missing write-back, interlaced: consumer inverts previous field identifier.
// [RL10] Consumer should confirm exact dimensions by querying the video decoder.
// [RL11] The controlling party supplies a fresh descriptor for every frame.
// [RL12] With write-back enabled, report field identifier, width and height.
// [RL13] At completion a held shadow becomes current, freeing the shadow.
// [RL14] A load with free shadow is stored as shadow, or current if empty.
package capture_pkg;

  localparam int DIM_W  = 12;
  localparam int ADDR_W = 32;
  localparam int SYNC_STAGES = 2;
  localparam int BUF_DEPTH   = 2;

  // Descriptor as loaded by the controlling party.
  typedef struct packed {
    logic [ADDR_W-1:0] wb_addr;
    logic              wb_en;
    logic [DIM_W-1:0]  width;
    logic [DIM_W-1:0]  height;
  } desc_t;

  localparam int DESC_W = $bits(desc_t);
  localparam desc_t DESC_RESET = '0;

  // Write-back record for the memory side.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              field_id;
    logic [DIM_W-1:0]  width;
    logic [DIM_W-1:0]  height;
  } wb_rec_t;

  localparam wb_rec_t WB_RESET = '0;

  // Report to the tracking unit for each delivery.
  typedef struct packed {
    desc_t desc;
    logic  accepted;
  } track_t;

  localparam track_t TRACK_RESET = '0;

  typedef enum logic [2:0] {
    ISSUE_IDLE   = 3'b001,
    ISSUE_FIRST  = 3'b010,
    ISSUE_SECOND = 3'b100
  } issue_state_t;

endpackage

// ==== src/desc_buffer.sv ====
`timescale 1ns/10ps
// Small FIFO in the descriptor path; ready drops when full so the source stalls.
module desc_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Wrapping pointers only index every entry when the depth is a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin
    $error("desc_buffer needs a power-of-two depth of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [PTR_W:0]   count_q;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_out  = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out  = mem_q[rd_q];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  // Pointers and count.
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

  // Storage needs no reset; only valid entries are ever read out.
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end

endmodule
